//--- pscp_ext_cpu.sv
`timescale 1ns/1ps
module pscp_ext_cpu (
  input  wire logic       clk,
  input  wire logic [7:0] bus,
  output logic      [2:0] strb,
  output logic      [7:0] dat,
  output logic            den
);
  initial begin
    strb = 3'h7;
    dat  = 8'h00;
    den  = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data settles before the strobes fall
  task automatic wr(input logic [7:0] d, input logic cs_n);
    dat <= d;
    den <= 1'b1;
    idle(6);
    strb <= {cs_n, 2'b01};
    idle(7);
    strb <= 3'h7;
    idle(7);
    den <= 1'b0;
    idle(1);
  endtask
  task automatic rd(output logic [7:0] d);
    strb <= 3'b010;
    idle(9);
    d = bus;
    strb <= 3'h7;
    idle(8);
  endtask
endmodule

//--- pscp_pkg.sv
package pscp_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_WIDE_PINS   = 8'h00;
  localparam logic [7:0] OFS_WIDE_LATCH  = 8'h04;
  localparam logic [7:0] OFS_WIDE_DIR    = 8'h08;
  localparam logic [7:0] OFS_CTL_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_NARROW_PINS = 8'h10;
  localparam logic [7:0] OFS_NARROW_LAT  = 8'h14;
  localparam logic [7:0] OFS_ANALOG_CFG  = 8'h18;

  // Decoded register index
  localparam logic [2:0] IDX_WIDE_PINS   = 3'h0;
  localparam logic [2:0] IDX_WIDE_LATCH  = 3'h1;
  localparam logic [2:0] IDX_WIDE_DIR    = 3'h2;
  localparam logic [2:0] IDX_CTL_STATUS  = 3'h3;
  localparam logic [2:0] IDX_NARROW_PINS = 3'h4;
  localparam logic [2:0] IDX_NARROW_LAT  = 3'h5;
  localparam logic [2:0] IDX_ANALOG_CFG  = 3'h6;
  localparam logic [2:0] IDX_NONE        = 3'h7;

  // Direction/status register fields
  localparam int ST_IBF  = 7;
  localparam int ST_OBF  = 6;
  localparam int ST_OVF  = 5;
  localparam int ST_MODE = 4;
  localparam int ST_GAP  = 3;

  // Control pin roles in slave mode
  localparam int PIN_RD = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_CS = 2;

  // Reset values
  localparam logic [7:0] RST_WIDE_DIR = 8'hff;
  localparam logic [2:0] RST_CTL_DIR  = 3'h7;
  localparam logic [2:0] RST_ANALOG   = 3'h7;
  localparam logic [7:0] RST_LATCH    = 8'h00;

  typedef enum logic [1:0] {
    PSCP_IDLE = 2'b00,
    PSCP_ACK  = 2'b01
  } pscp_apb_t;

  typedef struct packed {
    logic [7:0] wsync1;
    logic [7:0] wsync2;
    logic [7:0] wsync3;
    logic [7:0] wfilt;
    logic [2:0] csync1;
    logic [2:0] csync2;
    logic [2:0] csync3;
    logic [2:0] cfilt;
    logic       wr_act;
    logic       rd_act;
    logic [7:0] wide_lat;
    logic [7:0] wide_dir;
    logic [7:0] in_byte;
    logic [2:0] ctl_lat;
    logic [2:0] ctl_dir;
    logic [2:0] ana;
    logic       input_byte_full;
    logic       output_byte_full;
    logic       ovf;
    logic       mode;
    pscp_apb_t  apb;
    logic [31:0] rdata;
    logic       err;
  } pscp_state_t;

endpackage

//--- pscp_port.sv
`timescale 1ns/1ps
// Functional notes
// - Direction 1 tristates pin, 0 drives latch
// - Latch register reads back latched value
// - Exactly three control pins, each configurable
// - Analog-selected control pin reads as zero
// - Direction still drives pins in analog use
// - Reset makes control pins analog inputs
// - Bit 7 shows unread external byte
// - Bit 6 shows byte unread by outside
// - Bit 5 overflow, sticky until software clears
// - Bit 4 selects slave port mode
// - Bit 3 always reads zero
// - Status resets to 0000 -111
// - Selected read strobe drives data pins
// - Selected write strobe loads data byte
// - Chip select high blocks both strobes
// - Eight data pins serve GPIO or bus
// - Write recognised at first both-low detection, read at its release
module pscp_port
  import pscp_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  WIDE_I,
  output logic      [7:0]  WIDE_O,
  output logic      [7:0]  WIDE_OE_N,
  input  wire logic [2:0]  CTL_I,
  output logic      [2:0]  CTL_O,
  output logic      [2:0]  CTL_OE_N,
  output logic      [2:0]  ANALOG_SEL
);

  pscp_state_t q;
  pscp_state_t d;

  logic       setup;
  logic       access;
  logic [2:0] acc_idx;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_now;
  logic       rd_now;
  logic       wr_evt;
  logic       rd_end;

  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    logic [2:0] r;
    r = IDX_NONE;
    unique case (a)
      OFS_WIDE_PINS:   r = IDX_WIDE_PINS;
      OFS_WIDE_LATCH:  r = IDX_WIDE_LATCH;
      OFS_WIDE_DIR:    r = IDX_WIDE_DIR;
      OFS_CTL_STATUS:  r = IDX_CTL_STATUS;
      OFS_NARROW_PINS: r = IDX_NARROW_PINS;
      OFS_NARROW_LAT:  r = IDX_NARROW_LAT;
      OFS_ANALOG_CFG:  r = IDX_ANALOG_CFG;
      default:         r = IDX_NONE;
    endcase
    return r;
  endfunction

  // New level once the second and third stages agree
  function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] f);
    return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
  endfunction

  function automatic logic [7:0] status_byte(input pscp_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[ST_IBF]  = s.input_byte_full;
    v[ST_OBF]  = s.output_byte_full;
    v[ST_OVF]  = s.ovf;
    v[ST_MODE] = s.mode;
    v[ST_GAP]  = 1'b0;
    v[2:0]     = s.ctl_dir;
    return v;
  endfunction

  always_comb begin
    logic [7:0] rv;
    logic [7:0] cpad;
    rv   = 8'h00;
    cpad = 8'h00;
    d    = q;

    // Pin synchronisers
    d.wsync1 = WIDE_I;
    d.wsync2 = q.wsync1;
    d.wsync3 = q.wsync2;
    d.wfilt  = settle(q.wsync2, q.wsync3, q.wfilt);
    d.csync1 = CTL_I;
    d.csync2 = q.csync1;
    d.csync3 = q.csync2;
    cpad     = settle({5'h00, q.csync2}, {5'h00, q.csync3}, {5'h00, q.cfilt});
    d.cfilt  = cpad[2:0];

    // Strobe decode, write first-detection edge and read-end edge
    wr_now   = q.mode & ~q.cfilt[PIN_CS] & ~q.cfilt[PIN_WR];
    rd_now   = q.mode & ~q.cfilt[PIN_CS] & ~q.cfilt[PIN_RD];
    d.wr_act = wr_now;
    d.rd_act = rd_now;
    wr_evt   = wr_now & ~q.wr_act;
    rd_end   = q.rd_act & ~rd_now;

    // APB slave, one wait-free access phase
    setup   = PSEL & ~PENABLE;
    access  = PSEL & PENABLE & (q.apb == PSCP_ACK);
    acc_idx = reg_idx(PADDR);
    wr_fire = access & PWRITE & ~q.err;
    rd_fire = access & ~PWRITE & ~q.err;
    d.apb   = setup ? PSCP_ACK : PSCP_IDLE;

    if (setup) begin
      unique case (acc_idx)
        IDX_WIDE_PINS:   rv = q.mode ? q.in_byte : q.wfilt;
        IDX_WIDE_LATCH:  rv = q.wide_lat;
        IDX_WIDE_DIR:    rv = q.wide_dir;
        IDX_CTL_STATUS:  rv = status_byte(q);
        IDX_NARROW_PINS: rv = {5'h00, q.cfilt & ~q.ana};
        IDX_NARROW_LAT:  rv = {5'h00, q.ctl_lat};
        IDX_ANALOG_CFG:  rv = {5'h00, q.ana};
        IDX_NONE:        rv = 8'h00;
      endcase
      d.rdata = {24'h000000, rv};
      d.err   = (acc_idx == IDX_NONE);
    end

    // Hardware clears first so that sets below win
    if (rd_end) begin
      d.output_byte_full = 1'b0;
    end

    if (rd_fire && acc_idx == IDX_WIDE_PINS && q.mode) begin
      d.input_byte_full = 1'b0;
    end

    if (wr_fire) begin
      unique case (acc_idx)
        IDX_WIDE_PINS: begin
          d.wide_lat = PWDATA[7:0];
          if (q.mode) begin
            d.output_byte_full = 1'b1;
          end
        end
        IDX_WIDE_LATCH:  d.wide_lat = PWDATA[7:0];
        IDX_WIDE_DIR:    d.wide_dir = PWDATA[7:0];
        IDX_CTL_STATUS: begin
          d.ovf     = PWDATA[ST_OVF];
          d.mode    = PWDATA[ST_MODE];
          d.ctl_dir = PWDATA[2:0];
        end
        IDX_NARROW_PINS: d.ctl_lat = PWDATA[2:0];
        IDX_NARROW_LAT:  d.ctl_lat = PWDATA[2:0];
        IDX_ANALOG_CFG:  d.ana = PWDATA[2:0];
        IDX_NONE:        d.ctl_lat = q.ctl_lat;
      endcase
    end

    if (wr_evt) begin
      d.in_byte = q.wfilt;
      d.input_byte_full     = 1'b1;
      if (q.input_byte_full) begin
        d.ovf = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q          <= '0;
      q.wsync1   <= 8'h00;
      q.wide_lat <= RST_LATCH;
      q.wide_dir <= RST_WIDE_DIR;
      q.ctl_lat  <= RST_LATCH[2:0];
      q.ctl_dir  <= RST_CTL_DIR;
      q.ana      <= RST_ANALOG;
      q.apb      <= PSCP_IDLE;
    end else begin
      q <= d;
    end
  end

  assign PRDATA     = q.rdata;
  assign PREADY     = (q.apb == PSCP_ACK);
  assign PSLVERR    = q.err & (q.apb == PSCP_ACK);
  assign WIDE_O     = q.wide_lat;
  assign WIDE_OE_N  = q.mode ? {8{~q.rd_act}} : q.wide_dir;
  assign CTL_O      = q.ctl_lat;
  assign CTL_OE_N   = q.ctl_dir;
  assign ANALOG_SEL = q.ana;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  property p_dir_drive;
    !q.mode |-> (WIDE_OE_N == q.wide_dir) && (CTL_OE_N == q.ctl_dir) && (WIDE_O == q.wide_lat);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("Pin drive differs from direction");

  property p_analog_dir;
    (q.ana != 3'h0) |-> (CTL_OE_N == q.ctl_dir);
  endproperty
  a_analog_dir: assert property (p_analog_dir) else $error("Direction lost on analog pin");

  property p_analog_read;
    setup && !PWRITE && acc_idx == IDX_NARROW_PINS |=> (PRDATA[2:0] & $past(q.ana)) == 3'h0;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("Analog pin did not read zero");

  property p_latch_read;
    setup && !PWRITE && acc_idx == IDX_NARROW_LAT |=> PREADY && PRDATA[2:0] == $past(q.ctl_lat);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("Latch readback is not the latch");

  property p_gap_zero;
    setup && acc_idx == IDX_CTL_STATUS |=> PRDATA[ST_GAP] == 1'b0 && PRDATA[31:8] == 24'h000000;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("Unused status bit read as one");

  property p_reset_state;
    $fell(SYS_RST) |-> q.ctl_dir == RST_CTL_DIR && q.ana == RST_ANALOG && !q.mode && !q.input_byte_full && !q.ovf;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Bad state after reset");

  property p_write_load;
    wr_evt |=> q.input_byte_full && q.in_byte == $past(q.wfilt);
  endproperty
  a_write_load: assert property (p_write_load) else $error("External write not taken");

  property p_overflow;
    wr_evt && q.input_byte_full |=> q.ovf;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow not flagged");

  property p_ovf_sticky;
    q.ovf && !(wr_fire && acc_idx == IDX_CTL_STATUS) |=> q.ovf;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow dropped without a clear");

  property p_obf_clear;
    rd_end && !(wr_fire && acc_idx == IDX_WIDE_PINS) |=> !q.output_byte_full;
  endproperty
  a_obf_clear: assert property (p_obf_clear) else $error("Output-full not cleared");

  property p_read_drive;
    q.mode && q.rd_act |-> WIDE_OE_N == 8'h00 && WIDE_O == q.wide_lat;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("Data pins not driven on read");

  property p_cs_block;
    q.mode && q.cfilt[PIN_CS] |=> !$rose(q.input_byte_full) && !q.rd_act && !q.wr_act;
  endproperty
  a_cs_block: assert property (p_cs_block) else $error("Strobe acted while unselected");

  property p_mode_write;
    wr_fire && acc_idx == IDX_CTL_STATUS |=> q.mode == $past(PWDATA[ST_MODE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Mode bit not written");

  property p_mode_off;
    !q.mode |=> !$rose(q.input_byte_full) && !q.rd_act;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("Strobe acted in port mode");

  property p_dir_write;
    wr_fire && acc_idx == IDX_CTL_STATUS |=> CTL_OE_N == $past(PWDATA[2:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("Control direction not written");

  property p_latch_write;
    wr_fire && (acc_idx == IDX_WIDE_LATCH || acc_idx == IDX_WIDE_PINS) |=> WIDE_O == $past(PWDATA[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("Data latch not written");

  property p_gpio_pins;
    setup && !PWRITE && acc_idx == IDX_WIDE_PINS && !q.mode |=> PRDATA[7:0] == $past(q.wfilt);
  endproperty
  a_gpio_pins: assert property (p_gpio_pins) else $error("Data pins not read in port mode");

  property p_ibf_source;
    $rose(q.input_byte_full) |-> $past(wr_evt);
  endproperty
  a_ibf_source: assert property (p_ibf_source) else $error("Input-full set without external write");

  property p_obf_source;
    $rose(q.output_byte_full) |-> $past(wr_fire) && $past(acc_idx) == IDX_WIDE_PINS && $past(q.mode);
  endproperty
  a_obf_source: assert property (p_obf_source) else $error("Output-full set without CPU write");

  property p_ibf_clear;
    rd_fire && acc_idx == IDX_WIDE_PINS && q.mode && !wr_evt |=> !q.input_byte_full;
  endproperty
  a_ibf_clear: assert property (p_ibf_clear) else $error("Input-full not cleared by CPU read");

  property p_obf_set;
    wr_fire && acc_idx == IDX_WIDE_PINS && q.mode |=> q.output_byte_full;
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("Output-full not set by CPU write");

  property p_read_release;
    rd_end && q.mode && !wr_fire |=> WIDE_OE_N == 8'hff;
  endproperty
  a_read_release: assert property (p_read_release) else $error("Data pins still driven after read");

  property p_write_decode;
    q.mode && !q.cfilt[PIN_CS] && !q.cfilt[PIN_WR] && !q.wr_act |=> q.input_byte_full;
  endproperty
  a_write_decode: assert property (p_write_decode) else $error("Selected write strobe not taken");

  property p_first_detect;
    wr_evt |=> !wr_evt;
  endproperty
  a_first_detect: assert property (p_first_detect) else $error("Write recognised twice");

  property p_ctl_agree;
    q.csync2 == q.csync3 |=> q.cfilt == $past(q.csync3);
  endproperty
  a_ctl_agree: assert property (p_ctl_agree) else $error("Settled strobe level not taken");

  property p_ctl_hold;
    q.csync2 != q.csync3 |=> ((q.cfilt ^ $past(q.cfilt)) & ($past(q.csync2) ^ $past(q.csync3))) == 3'h0;
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("Unsettled strobe level taken");

  property p_wide_agree;
    q.wsync2 == q.wsync3 |=> q.wfilt == $past(q.wsync3);
  endproperty
  a_wide_agree: assert property (p_wide_agree) else $error("Settled data level not taken");

  c_ext_write: cover property (wr_evt);
  c_ext_read:  cover property (rd_end ##[1:50] wr_evt);
  c_overflow:  cover property (wr_evt && q.input_byte_full);
  c_cpu_take:  cover property (rd_fire && acc_idx == IDX_WIDE_PINS && q.input_byte_full);
  c_ovf_clear: cover property (q.ovf && wr_fire && acc_idx == IDX_CTL_STATUS);

endmodule

//--- pscp_port_bench.sv
`timescale 1ns/1ps
module pscp_port_bench
  import pscp_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, den, e;
  logic [7:0]  paddr, wide_o, wide_oe_n, wide_bus, dat, d;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  ctl_o, ctl_oe_n, ctl_bus, ana, strb;
  int          errors, n_tests, cyc;
  assign wide_bus = (~wide_oe_n & wide_o) | (wide_oe_n & (den ? dat : ~dat));
  assign ctl_bus  = (~ctl_oe_n & ctl_o) | (ctl_oe_n & strb);
  pscp_port i_pscp_port (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WIDE_I(wide_bus),
    .WIDE_O(wide_o), .WIDE_OE_N(wide_oe_n), .CTL_I(ctl_bus), .CTL_O(ctl_o), .CTL_OE_N(ctl_oe_n),
    .ANALOG_SEL(ana));
  pscp_ext_cpu i_pscp_ext_cpu (.clk(clk), .bus(wide_bus), .strb(strb), .dat(dat), .den(den));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), ex, r);
  endtask
  initial begin
    {psel, penable, pwrite, rst} = 4'b0001;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_CTL_STATUS, 32'h07);
    rdc(OFS_ANALOG_CFG, 32'h07);
    chk("analog_sel", 32'h7, {29'h0, ana});
    $display("reset test done");
    apb(1'b1, OFS_ANALOG_CFG, 32'h0);
    apb(1'b1, OFS_NARROW_LAT, 32'h06);
    apb(1'b1, OFS_CTL_STATUS, 32'h0a);
    rdc(OFS_CTL_STATUS, 32'h02);
    chk("ctl_oe_n", 32'h2, {29'h0, ctl_oe_n});
    repeat (5) @(posedge clk);
    rdc(OFS_NARROW_PINS, 32'h06);
    rdc(OFS_NARROW_LAT, 32'h06);
    apb(1'b1, OFS_NARROW_PINS, 32'h05);
    rdc(OFS_NARROW_LAT, 32'h05);
    apb(1'b1, OFS_ANALOG_CFG, 32'h7);
    chk("ctl_oe_n", 32'h2, {29'h0, ctl_oe_n});
    rdc(OFS_NARROW_PINS, 32'h00);
    apb(1'b1, OFS_CTL_STATUS, 32'h07);
    apb(1'b1, OFS_WIDE_LATCH, 32'ha5);
    apb(1'b1, OFS_WIDE_DIR, 32'h0f);
    chk("wide_oe_n", 32'h0f, {24'h0, wide_oe_n});
    repeat (5) @(posedge clk);
    rdc(OFS_WIDE_PINS, 32'haf);
    rdc(OFS_WIDE_LATCH, 32'ha5);
    $display("gpio test done");
    apb(1'b1, OFS_ANALOG_CFG, 32'h0);
    apb(1'b1, OFS_CTL_STATUS, 32'h17);
    i_pscp_ext_cpu.wr(8'h3c, 1'b0);
    rdc(OFS_CTL_STATUS, 32'h97);
    i_pscp_ext_cpu.wr(8'hc3, 1'b0);
    rdc(OFS_CTL_STATUS, 32'hb7);
    rdc(OFS_WIDE_PINS, 32'hc3);
    rdc(OFS_CTL_STATUS, 32'h37);
    apb(1'b1, OFS_CTL_STATUS, 32'h17);
    rdc(OFS_CTL_STATUS, 32'h17);
    apb(1'b1, OFS_WIDE_PINS, 32'h5a);
    rdc(OFS_CTL_STATUS, 32'h57);
    i_pscp_ext_cpu.rd(d);
    chk("ext read", 32'h5a, {24'h0, d});
    rdc(OFS_CTL_STATUS, 32'h17);
    i_pscp_ext_cpu.wr(8'h77, 1'b1);
    rdc(OFS_CTL_STATUS, 32'h17);
    $display("slave test done");
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("unmapped rdata", 32'h0, r);
    $display("unmapped test done");
    i_pscp_ext_cpu.wr(8'h11, 1'b0);
    rdc(OFS_CTL_STATUS, 32'h97);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFS_CTL_STATUS, 32'h07);
    rdc(OFS_ANALOG_CFG, 32'h07);
    rdc(OFS_NARROW_PINS, 32'h00);
    $display("second reset test done");
    summarize();
  end
endmodule
